// *** design/mcuex_pkg.sv ***
// shared constants and types for the instruction execution block
package mcuex_pkg;
  // clock and instruction cycle timing
  localparam int unsigned CLK_NS   = 50;
  localparam int unsigned TCY_NS   = 200;
  localparam int unsigned TCY_CLKS = (TCY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DIV_W    = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TCY_CLKS - 1);
  localparam logic [DIV_W-1:0] DIV_RST  = 3'h0;

  // register byte offsets
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_WORK  = 8'h04;
  localparam logic [7:0] REG_STAT  = 8'h08;
  localparam logic [7:0] REG_CTRL  = 8'h0C;
  localparam logic [7:0] REG_FADDR = 8'h10;
  localparam logic [7:0] REG_FDATA = 8'h14;
  localparam logic [7:0] REG_PSC   = 8'h18;

  // status and control bit positions
  localparam int unsigned ST_C    = 0;
  localparam int unsigned ST_DC   = 1;
  localparam int unsigned ST_Z    = 2;
  localparam int unsigned ST_BUSY = 3;
  localparam int unsigned ST_DISC = 4;
  localparam int unsigned CTRL_PSA = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // file space
  localparam int unsigned FILE_DEPTH = 128;
  localparam logic [6:0] FILE_TIMER_ZERO_COUNT = 7'h01;
  localparam logic [6:0] FILE_GPIO = 7'h05;
  localparam logic [7:0] BYTE_RST  = 8'h00;

  // instruction word fields
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned D_BIT   = 7;
  localparam int unsigned B_LO    = 7;
  localparam int unsigned B_HI    = 9;
  localparam logic [5:0] OPC_ADD_WORK_AND_FILE = 6'h07;
  localparam logic [5:0] OPC_AND_WORK_WITH_FILE = 6'h05;
  localparam logic [5:0] OPC_AND_LITERAL_WITH_WORK = 6'h39;
  localparam logic [4:0] OPC_ADD_LITERAL_TO_WORK = 5'h1F;
  localparam logic [1:0] OPC_BITS  = 2'h1;
  localparam logic [1:0] SUB_BCF   = 2'h0;
  localparam logic [1:0] SUB_BSF   = 2'h1;
  localparam logic [1:0] SUB_BIT_TEST_SKIP_IF_CLEAR = 2'h2;
  localparam logic [1:0] SUB_BIT_TEST_SKIP_IF_SET = 2'h3;
  localparam logic [13:0] INSTR_RST = 14'h0000;

  typedef enum {
    OP_NOP, OP_ADD_WORK_AND_FILE, OP_AND_WORK_WITH_FILE, OP_ADD_LITERAL_TO_WORK, OP_AND_LITERAL_WITH_WORK,
    OP_BCF, OP_BSF, OP_BIT_TEST_SKIP_IF_CLEAR, OP_BIT_TEST_SKIP_IF_SET
  } mcuex_op_type;

  typedef enum {ST_IDLE, ST_EXEC} mcuex_state_type;
endpackage : mcuex_pkg

// *** design/mcuex_alu.sv ***
// decode and arithmetic for one instruction word
`timescale 1ns/100ps
module mcuex_alu
  import mcuex_pkg::*;
(
  input  wire logic [INSTR_W-1:0] instr,
  input  wire logic [7:0]         w_in,
  input  wire logic [7:0]         f_in,
  output mcuex_op_type            op,
  output logic [7:0]              result,
  output logic                    c_out,
  output logic                    dc_out,
  output logic                    z_out,
  output logic                    upd_cdz,
  output logic                    upd_z,
  output logic                    wr_w,
  output logic                    wr_f,
  output logic                    skip
);
  logic [7:0] operand;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] mask;

  // decode first, then one result path per operation
  always_comb
  begin
    op = OP_NOP;
    if (instr[13:8] == OPC_ADD_WORK_AND_FILE)
      op = OP_ADD_WORK_AND_FILE;
    else if (instr[13:8] == OPC_AND_WORK_WITH_FILE)
      op = OP_AND_WORK_WITH_FILE;
    else if (instr[13:8] == OPC_AND_LITERAL_WITH_WORK)
      op = OP_AND_LITERAL_WITH_WORK;
    else if (instr[13:9] == OPC_ADD_LITERAL_TO_WORK)
      op = OP_ADD_LITERAL_TO_WORK;
    else if (instr[13:12] == OPC_BITS)
    begin
      case (instr[11:10])
        SUB_BCF:   op = OP_BCF;
        SUB_BSF:   op = OP_BSF;
        SUB_BIT_TEST_SKIP_IF_CLEAR: op = OP_BIT_TEST_SKIP_IF_CLEAR;
        default:   op = OP_BIT_TEST_SKIP_IF_SET;
      endcase
    end
    operand = (op == OP_ADD_LITERAL_TO_WORK || op == OP_AND_LITERAL_WITH_WORK) ? instr[7:0] : f_in;
    sum9    = {1'b0, w_in} + {1'b0, operand};
    nib5    = {1'b0, w_in[3:0]} + {1'b0, operand[3:0]};
    mask    = 8'h01 << instr[B_HI:B_LO];
    result  = w_in;
    upd_cdz = 1'b0;
    upd_z   = 1'b0;
    wr_w    = 1'b0;
    wr_f    = 1'b0;
    skip    = 1'b0;
    case (op)
      OP_ADD_WORK_AND_FILE, OP_ADD_LITERAL_TO_WORK:
      begin
        result  = sum9[7:0];
        upd_cdz = 1'b1;
      end
      OP_AND_WORK_WITH_FILE, OP_AND_LITERAL_WITH_WORK:
      begin
        result = w_in & operand;
        upd_z  = 1'b1;
      end
      OP_BCF:   result = f_in & ~mask;
      OP_BSF:   result = f_in | mask;
      OP_BIT_TEST_SKIP_IF_SET: skip = |(f_in & mask);
      OP_BIT_TEST_SKIP_IF_CLEAR: skip = ~|(f_in & mask);
      default:  result = w_in;
    endcase
    // literal forms always land in w, file forms follow the d bit
    case (op)
      OP_ADD_LITERAL_TO_WORK, OP_AND_LITERAL_WITH_WORK: wr_w = 1'b1;
      OP_ADD_WORK_AND_FILE, OP_AND_WORK_WITH_FILE:
      begin
        wr_w = ~instr[D_BIT];
        wr_f = instr[D_BIT];
      end
      OP_BCF, OP_BSF: wr_f = 1'b1;
      default: wr_w = 1'b0;
    endcase
    c_out  = sum9[8];
    dc_out = nib5[4];
    z_out  = (result == BYTE_RST);
  end
endmodule : mcuex_alu

// *** design/mcuex_core.sv ***
// instruction executor with file space, behind an AXI4-Lite slave
//
// Contract
// - read-modify-write of the I/O port takes its operand from the pins
// - writing the timer count clears the prescaler when it is assigned
// - a true conditional test costs two cycles, the second a no-op
// - add-literal adds 8-bit k to w, result in w, updates C, DC, Z
// - bit-clear forces bit b of file f to zero, flags unchanged
// - add-file adds w and file f, updates C, DC, Z
// - destination bit 0 writes w, 1 writes back to file f
// - bit-set forces bit b of file f to one, flags unchanged
// - AND-literal ands w with k into w, updates only Z
// - AND-file ands w with file f into destination, updates only Z
// - skip-if-set discards the next instruction when the bit is one
// - skip-if-clear discards the next instruction when the bit is zero
`timescale 1ns/100ps
module mcuex_core
  import mcuex_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        port_pins,
  output logic [7:0]             port_latch,
  output logic                   busy
);
  logic [7:0]        file_mem [FILE_DEPTH];
  mcuex_state_type   st_r, st_nxt;
  logic [DIV_W-1:0]  div_r, div_nxt;
  logic [13:0]       instr_r, instr_nxt;
  logic [7:0]        w_r, w_nxt, psc_r, psc_nxt, latch_r, latch_nxt;
  logic [6:0]        faddr_r, faddr_nxt;
  logic              c_r, c_nxt, dc_r, dc_nxt, z_r, z_nxt;
  logic              disc_r, disc_nxt, psa_r, psa_nxt, busy_r, busy_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]       wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0]        wstrb_r, wstrb_nxt;
  logic              awready_r, awready_nxt, wready_r, wready_nxt;
  logic              bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic              mem_we;
  logic [6:0]        mem_addr;
  logic [7:0]        mem_data;
  logic              tcy_en, exec_en, wr_fire, rd_fire, wr_ok;
  logic [7:0]        f_operand, sw_operand;
  mcuex_op_type      op;
  logic [7:0]        alu_res;
  logic              alu_c, alu_dc, alu_z, upd_cdz, upd_z;
  logic              wr_w, wr_f, skip;

  // the port address reads the pins, so a latch held high on a pulled-down
  // input pin is written back low
  assign f_operand  = (instr_r[6:0] == FILE_GPIO) ? port_pins
                    : file_mem[instr_r[6:0]];
  assign sw_operand = (faddr_r == FILE_GPIO) ? port_pins : file_mem[faddr_r];
  assign tcy_en  = (div_r == DIV_LAST);
  assign exec_en = (st_r == ST_EXEC) && tcy_en;
  assign wr_fire = !awready_r && !wready_r && !bvalid_r;
  assign rd_fire = s_axi_arvalid && arready_r;

  mcuex_alu u_alu (
    .instr   (instr_r),
    .w_in    (w_r),
    .f_in    (f_operand),
    .op      (op),
    .result  (alu_res),
    .c_out   (alu_c),
    .dc_out  (alu_dc),
    .z_out   (alu_z),
    .upd_cdz (upd_cdz),
    .upd_z   (upd_z),
    .wr_w    (wr_w),
    .wr_f    (wr_f),
    .skip    (skip)
  );

  // bus handshakes: address and data are caught in either order
  always_comb
  begin
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    wr_ok       = 1'b0;
    if (s_axi_awvalid && awready_r)
    begin
      awaddr_nxt  = s_axi_awaddr;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r)
    begin
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
      wready_nxt = 1'b0;
    end
    if (wr_fire)
    begin
      // a new instruction or file access while busy would race the core
      case (awaddr_r)
        // an owed discard slot still takes the next word, which it drops
        REG_INSTR:            wr_ok = (st_r == ST_IDLE);
        REG_FDATA, REG_WORK:  wr_ok = !busy_r;
        REG_CTRL, REG_FADDR:  wr_ok = 1'b1;
        default:              wr_ok = 1'b0;
      endcase
      bvalid_nxt = 1'b1;
      bresp_nxt  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt  = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
    if (rd_fire)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = RESP_OKAY;
      case (s_axi_araddr)
        REG_INSTR: rdata_nxt = {18'h00000, instr_r};
        REG_WORK:  rdata_nxt = {24'h000000, w_r};
        REG_STAT:  rdata_nxt = {27'h0000000, disc_r, busy_r, z_r, dc_r, c_r};
        REG_CTRL:  rdata_nxt = {31'h00000000, psa_r};
        REG_FADDR: rdata_nxt = {25'h0000000, faddr_r};
        REG_FDATA: rdata_nxt = {24'h000000, sw_operand};
        REG_PSC:   rdata_nxt = {24'h000000, psc_r};
        default:
        begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h00000000;
    end
    else
    begin
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // core: one instruction per instruction cycle, software writes when idle except control and file address
  always_comb
  begin
    st_nxt    = st_r;
    div_nxt   = tcy_en ? DIV_RST : div_r + 3'h1;
    instr_nxt = instr_r;
    w_nxt     = w_r;
    c_nxt     = c_r;
    dc_nxt    = dc_r;
    z_nxt     = z_r;
    disc_nxt  = disc_r;
    psa_nxt   = psa_r;
    faddr_nxt = faddr_r;
    latch_nxt = latch_r;
    psc_nxt   = (tcy_en && psa_r) ? psc_r + 8'h01 : psc_r;
    mem_we    = 1'b0;
    mem_addr  = faddr_r;
    mem_data  = wdata_r[7:0];
    if (wr_ok && wstrb_r[0])
    begin
      case (awaddr_r)
        REG_INSTR:
        begin
          instr_nxt = wdata_r[13:0];
          st_nxt    = ST_EXEC;
        end
        REG_WORK:  w_nxt = wdata_r[7:0];
        REG_CTRL:  psa_nxt = wdata_r[CTRL_PSA];
        REG_FADDR: faddr_nxt = wdata_r[6:0];
        default:   mem_we = 1'b1;
      endcase
    end
    if (exec_en)
    begin
      st_nxt = ST_IDLE;
      if (disc_r)
        disc_nxt = 1'b0;                         // no-op slot
      else
      begin
        disc_nxt = skip;
        mem_addr = instr_r[6:0];
        mem_data = alu_res;
        mem_we   = wr_f;
        if (wr_w)
          w_nxt = alu_res;
        if (upd_cdz)
        begin
          c_nxt  = alu_c;
          dc_nxt = alu_dc;
        end
        if (upd_cdz || upd_z)
          z_nxt = alu_z;
      end
    end
    // writes to the port also move the output latch
    if (mem_we && mem_addr == FILE_GPIO)
      latch_nxt = mem_data;
    if (mem_we && mem_addr == FILE_TIMER_ZERO_COUNT && psa_r)
      psc_nxt = BYTE_RST;
    busy_nxt = (st_nxt != ST_IDLE) || disc_nxt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r    <= ST_IDLE;
      div_r   <= DIV_RST;
      instr_r <= INSTR_RST;
      w_r     <= BYTE_RST;
      c_r     <= 1'b0;
      dc_r    <= 1'b0;
      z_r     <= 1'b0;
      disc_r  <= 1'b0;
      psa_r   <= 1'b0;
      faddr_r <= 7'h00;
      latch_r <= BYTE_RST;
      psc_r   <= BYTE_RST;
      busy_r  <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      div_r   <= div_nxt;
      instr_r <= instr_nxt;
      w_r     <= w_nxt;
      c_r     <= c_nxt;
      dc_r    <= dc_nxt;
      z_r     <= z_nxt;
      disc_r  <= disc_nxt;
      psa_r   <= psa_nxt;
      faddr_r <= faddr_nxt;
      latch_r <= latch_nxt;
      psc_r   <= psc_nxt;
      busy_r  <= busy_nxt;
    end
  end

  // file space has no reset; contents are undefined until written
  always_ff @(posedge aclk)
  begin
    if (mem_we)
      file_mem[mem_addr] <= mem_data;
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign port_latch    = latch_r;
  assign busy          = busy_r;

  a_port_operand: assert property (@(posedge aclk) disable iff (!aresetn)
    (instr_r[6:0] == FILE_GPIO) |-> f_operand == port_pins)
    else $error("port operand not taken from pins");
  a_psc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_en && !disc_r && wr_f && instr_r[6:0] == FILE_TIMER_ZERO_COUNT && psa_r
    |=> psc_r == BYTE_RST)
    else $error("prescaler not cleared by timer write");
  a_skip_nop: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_en && disc_r |=> $stable(w_r) && $stable(z_r) && !disc_r)
    else $error("discarded slot changed state");
  a_add_lit: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_en && !disc_r && op == OP_ADD_LITERAL_TO_WORK
    |=> w_r == 8'($past(w_r) + $past(instr_r[7:0])))
    else $error("literal add result wrong");
  a_bit_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_en && !disc_r && (op == OP_BCF || op == OP_BSF)
    |=> $stable(c_r) && $stable(dc_r) && $stable(z_r))
    else $error("bit op touched flags");
  a_add_carry: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_en && !disc_r && op == OP_ADD_WORK_AND_FILE
    |=> c_r == $past(alu_c) && dc_r == $past(alu_dc))
    else $error("file add flags wrong");
  a_dest_file: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_en && !disc_r && op == OP_AND_WORK_WITH_FILE && instr_r[D_BIT]
    |=> $stable(w_r))
    else $error("file destination altered w");
  a_and_zflag: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_en && !disc_r && (op == OP_AND_LITERAL_WITH_WORK || op == OP_AND_WORK_WITH_FILE)
    |=> $stable(c_r) && z_r == $past(alu_z))
    else $error("and flags wrong");
  a_skip_set: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_en && !disc_r && op == OP_BIT_TEST_SKIP_IF_SET
    |=> disc_r == $past(f_operand[instr_r[B_HI:B_LO]]))
    else $error("skip-if-set polarity wrong");
  a_skip_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_en && !disc_r && op == OP_BIT_TEST_SKIP_IF_CLEAR
    |=> disc_r != $past(f_operand[instr_r[B_HI:B_LO]]))
    else $error("skip-if-clear polarity wrong");
  a_zero_res: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_en && !disc_r && op == OP_ADD_LITERAL_TO_WORK
    |=> z_r == (w_r == BYTE_RST))
    else $error("zero flag disagrees with result");
endmodule : mcuex_core

// *** test/mcuex_pin_model.sv ***
// external device model that can overdrive the io port pins
`timescale 1ns/100ps
module mcuex_pin_model (
  input  wire logic [7:0] port_latch,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic [7:0]      port_pins
);
  // an overdriven pin shows the outside level, so it can differ from the
  // latch bit; that difference is what a read-modify-write must pick up
  assign port_pins = (ext_en & ext_val) | (~ext_en & port_latch);
endmodule : mcuex_pin_model

// *** test/mcu_instruction_exec_subset_tb.sv ***
// self-checking testbench for the instruction execution block
`timescale 1ns/100ps
module mcu_instruction_exec_subset_tb;
  import mcuex_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [7:0]  port_pins;
  logic [7:0]  port_latch;
  logic        busy;
  logic [7:0]  ext_en = 8'h00;
  logic [7:0]  ext_val = 8'h00;
  logic [2:0]  fl = 3'h0;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;

  mcuex_core uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .port_pins(port_pins),
    .port_latch(port_latch), .busy(busy));

  mcuex_pin_model pins (.port_latch(port_latch), .ext_en(ext_en),
    .ext_val(ext_val), .port_pins(port_pins));

  // 50 ns period
  always #25 aclk = ~aclk;

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // a hang anywhere ends the run here instead of stalling forever
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t timeout", $time);
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    r = 2'bxx;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    // one edge between transfers so no strobe is assigned twice at once
    @(posedge aclk);
  endtask : wr

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "write resp");
  endtask : wr_ok

  task automatic rdv(input logic [7:0] a, output logic [31:0] d);
    d = 32'hx;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask : rdv

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string m);
    logic [31:0] d;
    rdv(a, d);
    chk(d, exp, m);
  endtask : rd

  // busy covers the wait for the next instruction-cycle slot
  task automatic idle();
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge aclk);
    chk({31'h0, busy}, 32'h0, "busy stuck");
    repeat (2) @(posedge aclk);
  endtask : idle

  task automatic ex(input logic [13:0] ins);
    wr_ok(REG_INSTR, {18'h0, ins});
    idle();
  endtask : ex

  task automatic add_exp(input logic [7:0] w, input logic [7:0] k,
                         output logic [7:0] s);
    logic [8:0] t;
    logic [4:0] h;
    t = {1'b0, w} + {1'b0, k};
    h = {1'b0, w[3:0]} + {1'b0, k[3:0]};
    s = t[7:0];
    fl = {t[7:0] == 8'h00, h[4], t[8]};
  endtask : add_exp

  task automatic t_reset();
    logic [1:0] r;
    rd(REG_WORK, 32'h0, "work reset");
    rd(REG_STAT, 32'h0, "status reset");
    rd(REG_CTRL, 32'h0, "ctrl reset");
    rd(REG_PSC, 32'h0, "prescaler reset");
    wr(REG_STAT, 32'hFF, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "status write refused");
    rd(REG_STAT, 32'h0, "status after refused write");
    $display("test reset done");
  endtask : t_reset

  task automatic t_lit();
    logic [7:0] wv[3] = '{8'h7E, 8'h0F, 8'h8F};
    logic [7:0] kv[3] = '{8'h01, 8'h01, 8'h71};
    logic [7:0] s;
    for (int i = 0; i < 3; i++)
    begin
      wr_ok(REG_WORK, {24'h0, wv[i]});
      ex(14'h3E00 | {6'h0, kv[i]});
      add_exp(wv[i], kv[i], s);
      rd(REG_WORK, {24'h0, s}, "add literal");
      rd(REG_STAT, {29'h0, fl}, "add literal flags");
    end
    // carry and digit carry are set now and must survive the ands
    wr_ok(REG_WORK, 32'hF0);
    ex(14'h393C);
    fl[2] = 1'b0;
    rd(REG_WORK, 32'h30, "and literal");
    rd(REG_STAT, {29'h0, fl}, "and literal flags");
    ex(14'h390F);
    fl[2] = 1'b1;
    rd(REG_WORK, 32'h00, "and literal zero");
    rd(REG_STAT, {29'h0, fl}, "and literal zero flag");
    $display("test literal done");
  endtask : t_lit

  task automatic t_file();
    logic [7:0]  w;
    logic [7:0]  f;
    logic [7:0]  res;
    logic        d;
    logic        is_and;
    w = 8'hA5;
    f = 8'h5B;
    for (int i = 0; i < 4; i++)
    begin
      is_and = i[1];
      d = i[0];
      wr_ok(REG_FADDR, 32'h20);
      wr_ok(REG_FDATA, {24'h0, f});
      wr_ok(REG_WORK, {24'h0, w});
      ex((is_and ? 14'h0500 : 14'h0700) | {6'h0, d, 7'h20});
      if (is_and)
      begin
        res = w & f;
        fl[2] = (res == 8'h00);
      end
      else
        add_exp(w, f, res);
      rd(REG_WORK, {24'h0, d ? w : res}, "file op work");
      rd(REG_FDATA, {24'h0, d ? res : f}, "file op file");
      rd(REG_STAT, {29'h0, fl}, "file op flags");
    end
    $display("test file done");
  endtask : t_file

  task automatic t_bits();
    logic [7:0] e;
    wr_ok(REG_FADDR, 32'h21);
    wr_ok(REG_FDATA, 32'h00);
    e = 8'h00;
    for (int b = 0; b < 8; b++)
    begin
      ex(14'h1400 | {4'h0, b[2:0], 7'h21});
      e[b] = 1'b1;
      rd(REG_FDATA, {24'h0, e}, "bit set");
    end
    for (int b = 0; b < 8; b++)
    begin
      ex(14'h1000 | {4'h0, b[2:0], 7'h21});
      e[b] = 1'b0;
      rd(REG_FDATA, {24'h0, e}, "bit clear");
    end
    rd(REG_STAT, {29'h0, fl}, "bit ops keep flags");
    $display("test bits done");
  endtask : t_bits

  task automatic t_skip();
    logic [13:0] op[4] = '{14'h1C00, 14'h1C00, 14'h1800, 14'h1800};
    logic [2:0]  bt[4] = '{3'h2, 3'h3, 3'h3, 3'h2};
    logic [1:0]  r;
    logic [7:0]  s;
    wr_ok(REG_FADDR, 32'h22);
    wr_ok(REG_FDATA, 32'h04);
    for (int i = 0; i < 4; i++)
    begin
      wr_ok(REG_WORK, 32'h10);
      wr_ok(REG_INSTR, {18'h0, op[i] | {4'h0, bt[i], 7'h22}});
      if (i == 0 || i == 2)
      begin
        // the owed slot keeps busy up until the next word arrives and is dropped
        repeat (8) @(posedge aclk);
        chk({31'h0, busy}, 32'h1, "skip busy");
        rd(REG_STAT, {27'h0, 2'h3, fl}, "skip pending");
        wr(REG_WORK, 32'h55, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR}, "work write while busy");
        ex(14'h3E01);
        rd(REG_WORK, 32'h10, "skipped word discarded");
      end
      else
      begin
        idle();
        ex(14'h3E01);
        add_exp(8'h10, 8'h01, s);
        rd(REG_WORK, {24'h0, s}, "next word runs");
      end
      rd(REG_STAT, {29'h0, fl}, "skip settled");
    end
    $display("test skip done");
  endtask : t_skip

  task automatic t_port();
    wr_ok(REG_FADDR, 32'h05);
    wr_ok(REG_FDATA, 32'hFF);
    chk({24'h0, port_latch}, 32'hFF, "latch loaded");
    // outside device pulls the low nibble down against the latch
    ext_en <= 8'h0F;
    ext_val <= 8'h00;
    ex(14'h1785);
    chk({24'h0, port_latch}, 32'hF0, "rmw uses pins");
    rd(REG_FDATA, 32'hF0, "port reads pins");
    ext_en <= 8'h00;
    $display("test port done");
  endtask : t_port

  task automatic t_tmr();
    logic [31:0] p;
    wr_ok(REG_CTRL, 32'h1);
    repeat (60) @(posedge aclk);
    rdv(REG_PSC, p);
    n_checks++;
    if (p < 32'h8)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t prescaler not counting", $time);
    end
    // bit set on the timer count must restart the prescaler
    ex(14'h1401);
    wr_ok(REG_CTRL, 32'h0);
    rdv(REG_PSC, p);
    n_checks++;
    if (p > 32'h3)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t timer write kept prescaler", $time);
    end
    rd(REG_PSC, p, "prescaler frozen when unassigned");
    $display("test timer done");
  endtask : t_tmr

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_lit();
    t_file();
    t_bits();
    t_skip();
    t_port();
    t_tmr();
    test_done();
  end
endmodule : mcu_instruction_exec_subset_tb
